/* shared/stepper_pkg.sv */
// Package for the step sequencer and chop synchronisation block
package stepper_pkg;

    // ------------------------------------------------------------
    // Sequence and mode encoding
    // ------------------------------------------------------------
    localparam int unsigned STEP_W     = 5;
    localparam logic [4:0]  HOME_STEP  = 5'h00;
    localparam logic [4:0]  STEP_MASK  = 5'h1F;
    localparam int unsigned RATIO_W    = 8;
    localparam int unsigned VREF_W     = 8;
    localparam int unsigned TRIP_W     = 8;
    localparam int unsigned TRIP_DIV   = 3;

    // Trip ratio per eighth step of a quarter wave, entry 0 is full scale
    localparam logic [7:0][RATIO_W-1:0] RATIO_TAB = {
        8'h32, 8'h62, 8'h8E, 8'hB4, 8'hD4, 8'hEC, 8'hFA, 8'hFF
    };

    // Stepping modes: full, half, quarter, eighth
    typedef enum logic [1:0] {
        MODE_FULL    = 2'h0,
        MODE_HALF    = 2'h1,
        MODE_QUARTER = 2'h2,
        MODE_EIGHTH  = 2'h3
    } step_mode_e;

    // Step increments per mode, in eighth-step units
    localparam logic [4:0] INC_FULL    = 5'h08;
    localparam logic [4:0] INC_HALF    = 5'h04;
    localparam logic [4:0] INC_QUARTER = 5'h02;
    localparam logic [4:0] INC_EIGHTH  = 5'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned OFF_TIME_NS    = 10000;
    localparam int unsigned OFF_CYCLES     = OFF_TIME_NS * CLK_MHZ / 1000;
    localparam int unsigned OFF_W          = 10;
    localparam int unsigned SYNC_TMO_US    = 10000;
    localparam int unsigned SYNC_TMO_CYC   = SYNC_TMO_US * CLK_MHZ;
    localparam int unsigned SYNC_W         = 24;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       step_clk;
        logic       seq_reset;
        logic       sync_sel;
        logic       sync_from_clk;
        logic       dir_ccw;
        step_mode_e mode;
        logic       full_disable;
        logic       ref_sleep;
    } ctrl_in_s;

    typedef struct packed {
        logic [3:0]        phase_on;
        logic [TRIP_W-1:0] trip_a;
        logic [TRIP_W-1:0] trip_b;
    } drive_out_s;

endpackage : stepper_pkg

/* verilog/pwm_chopper.sv */
// Fixed off-time chopper for one coil pair
`timescale 1ns/1ps
module pwm_chopper
    import stepper_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic enable,
    input  wire logic trip,
    input  wire logic sync_start,
    output logic      pwm_on,
    output logic      off_done
);

    logic [OFF_W-1:0] off_cnt;

    // [RQ15] Off-time after trip
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_on  <= 1'b0;
            off_cnt <= '0;
        end
        else if (clk_en)
        begin
            if (!enable)
            begin
                pwm_on  <= 1'b0;
                off_cnt <= '0;
            end
            else if (pwm_on)
            begin
                if (trip)
                begin
                    pwm_on  <= 1'b0;
                    off_cnt <= OFF_W'(OFF_CYCLES - 1);
                end
            end
            else if (off_cnt != '0)
                off_cnt <= off_cnt - OFF_W'(1);
            // [RQ8] Restart only on the shared start
            else if (sync_start)
                pwm_on <= 1'b1;
        end
    end

    // Off-time spent; parent builds the shared start from this
    assign off_done = !pwm_on && (off_cnt == '0);

    AST_OFF_TIME: assert property ( // [RQ15]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && enable && pwm_on && trip |=> !pwm_on)
        else $error("chopper did not turn off on trip");

endmodule : pwm_chopper

/* verilog/stepper_seq.sv */
// Step sequencer with chop synchronisation and trip reference
// Behaviour
// [RQ1] Power-on reset initialises the sequencer with no outside action.
// [RQ2] After initialisation the drive sits at the home excitation step.
// [RQ3] Sequencer reset input returns the sequence to home.
// [RQ4] Controller ties sequencer reset low when unused.
// [RQ5] No step-clock edges: the present step is held.
// [RQ6] Hold is the same for a low or high idle clock level.
// [RQ7] Each rising step-clock edge advances one mode increment.
// [RQ8] Chop sync select high enables synchronised chopping.
// [RQ9] Controller keeps chop sync off while stepping.
// [RQ10] Controller enables sync only at steps 8, F or single hold.
// [RQ11] Step clock high clears the derived sync, normal chopping.
// [RQ12] Clock low beyond timeout raises derived sync.
// [RQ13] Controller picks the timeout from its lowest step rate.
// [RQ14] Controller inverts a clock that parks high; the model does not invert it, it clears sync_from_clk before idling high.
// [RQ15] Self-oscillating PWM: on until trip, then fixed off-time.
// [RQ16] Trip reference is one third of reference times step ratio.
// [RQ17] Full disable holds sequencer; reference sleep keeps it running.
// [RQ18] Controller waits 100 us after disable before stepping.
// [RQ19] Derived sync uses a counter cleared while clock high.
`timescale 1ns/1ps
module stepper_seq
    import stepper_pkg::*;
#(
    parameter int unsigned SYNC_TIMEOUT = SYNC_TMO_CYC
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire ctrl_in_s          ctrl,
    input  wire logic [VREF_W-1:0] vref,
    input  wire logic [1:0]        coil_trip,
    output drive_out_s             drive,
    output logic [STEP_W-1:0]      step_pos,
    output logic                   sync_active
);

    // ------------------------------------------------------------
    // Ratio table, one entry per eighth step of a quarter wave
    // ------------------------------------------------------------
    function automatic logic [RATIO_W-1:0] ratio_of(
        input logic [2:0] idx
    );
        return RATIO_TAB[idx];
    endfunction : ratio_of

    function automatic logic [TRIP_W-1:0] trip_of(
        input logic [VREF_W-1:0]  v,
        input logic [RATIO_W-1:0] r
    );
        logic [VREF_W+RATIO_W-1:0] prod;
        prod = (v * r) / (VREF_W+RATIO_W)'(TRIP_DIV);
        return prod[VREF_W+RATIO_W-1:RATIO_W];
    endfunction : trip_of

    // ------------------------------------------------------------
    // Edge detection on the step clock
    // ------------------------------------------------------------
    logic clk_prev;
    logic armed;
    logic rise;

    // [RQ6] Level only stored
    // First cycle after reset only learns the level: a clock parked
    // high must not look like an edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_prev <= 1'b0;
            armed    <= 1'b0;
        end
        else if (clk_en)
        begin
            clk_prev <= ctrl.step_clk;
            armed    <= 1'b1;
        end
    end

    assign rise = armed && ctrl.step_clk && !clk_prev;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic [4:0] inc;
    logic [4:0] next_step;

    always_comb
    begin
        unique case (ctrl.mode)
            MODE_FULL:    inc = INC_FULL;
            MODE_HALF:    inc = INC_HALF;
            MODE_QUARTER: inc = INC_QUARTER;
            MODE_EIGHTH:  inc = INC_EIGHTH;
        endcase
        next_step = ctrl.dir_ccw ? (step_pos - inc) & STEP_MASK
                                 : (step_pos + inc) & STEP_MASK;
    end

    // [RQ1] [RQ2] [RQ3] Home on reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            step_pos <= HOME_STEP;
        else if (clk_en)
        begin
            if (ctrl.seq_reset)
                step_pos <= HOME_STEP;
            // [RQ7] [RQ17] Advance unless disabled
            else if (rise && !ctrl.full_disable)
                step_pos <= next_step;
            // [RQ5] Otherwise hold
        end
    end

    // ------------------------------------------------------------
    // Chop synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] low_cnt;
    logic              derived_sync;

    // [RQ19] [RQ11] Counter cleared while clock high
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt      <= '0;
            derived_sync <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ctrl.step_clk)
            begin
                low_cnt      <= '0;
                derived_sync <= 1'b0;
            end
            // [RQ12] Timeout raises sync
            else if (low_cnt >= SYNC_W'(SYNC_TIMEOUT - 1))
                derived_sync <= 1'b1;
            else
                low_cnt <= low_cnt + SYNC_W'(1);
        end
    end

    // [RQ8] Select or derived sync
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_active <= 1'b0;
        else if (clk_en)
            sync_active <= ctrl.sync_from_clk ? derived_sync : ctrl.sync_sel;
    end

    // ------------------------------------------------------------
    // Phase and trip reference
    // ------------------------------------------------------------
    logic [2:0] idx_a;
    logic [2:0] idx_b;
    logic       quad_odd;
    logic [1:0] quad;
    logic       run;
    logic [1:0] pwm_on;
    logic [1:0] restart;
    logic       all_done;

    logic [TRIP_W-1:0] trip_a;
    logic [TRIP_W-1:0] trip_b;
    logic [3:0]        phase_on;

    assign drive = '{phase_on: phase_on, trip_a: trip_a, trip_b: trip_b};

    assign quad     = step_pos[4:3];
    assign quad_odd = quad[0];
    assign idx_a    = quad_odd ? ~step_pos[2:0] : step_pos[2:0];
    assign idx_b    = quad_odd ? step_pos[2:0] : ~step_pos[2:0];
    // Reference sleep and full disable both coast the outputs
    assign run      = !ctrl.full_disable && !ctrl.ref_sleep;

    // [RQ16] Trip per step
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trip_a <= '0;
            trip_b <= '0;
        end
        else if (clk_en)
        begin
            trip_a <= trip_of(vref, ratio_of(idx_a));
            trip_b <= trip_of(vref, ratio_of(idx_b));
        end
    end

    // Shared restart when synchronised, so both phases chop together
    // A coil that never trips keeps the other one off while synchronised
    assign all_done = &restart;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_coil
            pwm_chopper u_chop (
                .sys_clk    (sys_clk),
                .rst_n      (rst_n),
                .clk_en     (clk_en),
                .enable     (run),
                .trip       (coil_trip[g]),
                .sync_start (sync_active ? all_done : 1'b1),
                .pwm_on     (pwm_on[g]),
                .off_done   (restart[g])
            );
        end
    endgenerate

    // [RQ15] Drive phases from PWM state
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_on <= '0;
        else if (clk_en)
        begin
            phase_on[0] <= pwm_on[0] && !quad[1];
            phase_on[1] <= pwm_on[0] && quad[1];
            phase_on[2] <= pwm_on[1] && (quad == 2'h1 || quad == 2'h2);
            phase_on[3] <= pwm_on[1] && !(quad == 2'h1 || quad == 2'h2);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RESET_HOME: assert property ( // [RQ3]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && ctrl.seq_reset |=> step_pos == HOME_STEP)
        else $error("sequence reset did not return home");

    AST_HOLD: assert property ( // [RQ5]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && !ctrl.seq_reset && !rise |=> $stable(step_pos))
        else $error("step moved without a rising edge");

    AST_ADVANCE: assert property ( // [RQ7]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && rise && !ctrl.seq_reset && !ctrl.full_disable
        |=> step_pos == $past(next_step))
        else $error("step did not advance one increment");

    AST_DISABLE_HOLD: assert property ( // [RQ17]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && ctrl.full_disable && !ctrl.seq_reset
        |=> $stable(step_pos))
        else $error("sequencer moved in full disable");

    AST_SYNC_CLEAR: assert property ( // [RQ11]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && ctrl.step_clk |=> !derived_sync && low_cnt == '0)
        else $error("derived sync not cleared by high clock");

    AST_SYNC_SEL: assert property ( // [RQ8]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && !ctrl.sync_from_clk
        |=> sync_active == $past(ctrl.sync_sel))
        else $error("sync select not followed");

    AST_SYNC_RISE: assert property ( // [RQ12]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en && !ctrl.step_clk && low_cnt >= SYNC_W'(SYNC_TIMEOUT - 1)
        |=> derived_sync)
        else $error("derived sync did not rise after timeout");

    AST_TRIP: assert property ( // [RQ16]
        @(posedge sys_clk) disable iff (!rst_n)
        clk_en
        |=> drive.trip_a == trip_of($past(vref), ratio_of($past(idx_a))))
        else $error("trip reference mismatch");

endmodule : stepper_seq

/* tb/ctrl_model.sv */
// Controller model that drives the sequencer control levels
`timescale 1ns/1ps
module ctrl_model
    import stepper_pkg::*;
#(
    parameter int unsigned WAKE_CYC = 10000
)
(
    input  wire logic sys_clk,
    output ctrl_in_s  ctrl
);
    // ------------------------------------------------
    // Control sequences
    // ------------------------------------------------
    // reset idles low
    initial ctrl = '0;
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(negedge sys_clk) ctrl.step_clk = 1'h1;
            @(negedge sys_clk) ctrl.step_clk = 1'h0;
        end
    endtask : pulse
    task automatic set_mode(input step_mode_e m, input logic ccw);
        @(negedge sys_clk);
        ctrl.mode    = m;
        ctrl.dir_ccw = ccw;
    endtask : set_mode
    task automatic idle(input int n, input logic lvl);
        @(negedge sys_clk);
        if (lvl)
            ctrl.sync_from_clk = 1'h0;
        ctrl.step_clk = lvl;
        repeat (n) @(negedge sys_clk);
    endtask : idle
    task automatic home_pulse;
        @(negedge sys_clk) ctrl.seq_reset = 1'h1;
        pulse(1);
        @(negedge sys_clk) ctrl.seq_reset = 1'h0;
    endtask : home_pulse
    task automatic sleep(input logic full, input logic refs);
        @(negedge sys_clk);
        ctrl.full_disable = full;
        ctrl.ref_sleep    = refs;
        if (!full && !refs)
            repeat (WAKE_CYC) @(negedge sys_clk);
    endtask : sleep
    task automatic sync_pin(input logic v);
        @(negedge sys_clk) ctrl.sync_sel = v;
    endtask : sync_pin
    task automatic derive(input logic v);
        @(negedge sys_clk) ctrl.sync_from_clk = v;
    endtask : derive
endmodule : ctrl_model

/* tb/tb.sv */
// Self-checking bench for the step sequencer
`timescale 1ns/1ps
module tb
    import stepper_pkg::*;
;
    localparam int unsigned TMO = 20;
    logic              sys_clk;
    logic              rst_n;
    logic              clk_en;
    logic [VREF_W-1:0] vref;
    logic [1:0]        coil_trip;
    ctrl_in_s          ctrl;
    drive_out_s        drive;
    logic [STEP_W-1:0] step_pos;
    logic              sync_active;
    logic [STEP_W-1:0] exp_pos;
    int                n_mismatch;
    int                checks;

    ctrl_model u_ctrl (.sys_clk(sys_clk), .ctrl(ctrl));
    stepper_seq #(.SYNC_TIMEOUT(TMO)) u_dut (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .ctrl        (ctrl),
        .vref        (vref),
        .coil_trip   (coil_trip),
        .drive       (drive),
        .step_pos    (step_pos),
        .sync_active (sync_active)
    );
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [4:0] adv();
        logic [4:0] inc;
        case (ctrl.mode)
            MODE_FULL:    inc = INC_FULL;
            MODE_HALF:    inc = INC_HALF;
            MODE_QUARTER: inc = INC_QUARTER;
            default:      inc = INC_EIGHTH;
        endcase
        return ctrl.dir_ccw ? exp_pos - inc : exp_pos + inc;
    endfunction : adv
    function automatic logic [7:0] exp_trip(input logic [2:0] i);
        logic [15:0] p;
        p = 16'(vref * RATIO_TAB[i] / TRIP_DIV);
        return p[15:8];
    endfunction : exp_trip
    task automatic trip_pulse(input logic [1:0] c);
        coil_trip = c;
        @(negedge sys_clk);
        coil_trip = 2'h0;
        @(negedge sys_clk);
    endtask : trip_pulse
    task automatic cmp_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] s);
        checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input string nm, input logic e, input logic s);
        cmp_byte(nm, {7'h00, e}, {7'h00, s});
    endtask : cmp_bit
    task automatic cmp_pos(input string nm);
        cmp_byte(nm, {3'h0, exp_pos}, {3'h0, step_pos});
    endtask : cmp_pos
    task automatic step(input int n);
        u_ctrl.pulse(n);
        repeat (n) exp_pos = adv();
        @(negedge sys_clk);
    endtask : step
    task automatic end_sim;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_modes;
        for (int i = 0; i < 8; i++)
        begin
            u_ctrl.set_mode(step_mode_e'(i[1:0]), i[2]);
            step(3);
            cmp_pos("step_pos"); // one increment each
        end
        cmp_byte("trip_a_full", exp_trip(3'h0), drive.trip_a);
        cmp_byte("trip_b_low", exp_trip(3'h7), drive.trip_b);
        vref = 8'h00;
        repeat (3) @(negedge sys_clk);
        cmp_byte("trip_a", 8'h00, drive.trip_a); // zero reference
        cmp_byte("trip_b", 8'h00, drive.trip_b); // zero reference
        vref = 8'hC0;
    endtask : t_modes
    task automatic t_hold;
        u_ctrl.idle(30, 1'h0);
        cmp_pos("hold_low"); // held while low
        exp_pos = adv();
        u_ctrl.idle(30, 1'h1);
        cmp_pos("hold_high"); // held while high
        u_ctrl.idle(2, 1'h0);
        clk_en = 1'h0;
        u_ctrl.pulse(2);
        clk_en = 1'h1;
        @(negedge sys_clk);
        cmp_pos("frozen"); // no step while frozen
    endtask : t_hold
    task automatic t_home;
        step(1);
        u_ctrl.home_pulse();
        exp_pos = HOME_STEP;
        @(negedge sys_clk);
        cmp_pos("home_again"); // back at home
    endtask : t_home
    task automatic t_disable;
        step(1);
        u_ctrl.sleep(1'h1, 1'h0);
        u_ctrl.pulse(2);
        cmp_pos("full_disable"); // edges ignored
        cmp_byte("full_coast", 8'h00, {4'h0, drive.phase_on});
        u_ctrl.sleep(1'h0, 1'h0);
        u_ctrl.sleep(1'h0, 1'h1);
        step(2);
        cmp_pos("ref_sleep"); // still stepping
        cmp_byte("ref_coast", 8'h00, {4'h0, drive.phase_on});
        u_ctrl.sleep(1'h0, 1'h0);
    endtask : t_disable
    task automatic t_sync;
        u_ctrl.sync_pin(1'h1);
        repeat (3) @(negedge sys_clk);
        cmp_bit("sync_on", 1'h1, sync_active); // select high
        u_ctrl.sync_pin(1'h0);
        repeat (3) @(negedge sys_clk);
        cmp_bit("sync_off", 1'h0, sync_active); // select low
        u_ctrl.derive(1'h1);
        step(1);
        repeat (TMO / 2) @(negedge sys_clk);
        cmp_bit("derived_early", 1'h0, sync_active);
        repeat (TMO) @(negedge sys_clk);
        cmp_bit("derived_late", 1'h1, sync_active); // timed out
        step(1);
        repeat (2) @(negedge sys_clk);
        cmp_bit("derived_clear", 1'h0, sync_active); // cleared
        cmp_pos("sync_step"); // still advances
        u_ctrl.derive(1'h0);
    endtask : t_sync
    task automatic t_reset;
        u_ctrl.idle(2, 1'h1);
        rst_n = 1'h0;
        repeat (4) @(negedge sys_clk);
        rst_n   = 1'h1;
        exp_pos = HOME_STEP;
        repeat (2) @(negedge sys_clk);
        cmp_pos("reset_mid"); // no false edge
        u_ctrl.idle(2, 1'h0);
    endtask : t_reset
    task automatic t_chop;
        trip_pulse(2'h1);
        cmp_bit("chop_off", 1'h0, |drive.phase_on[1:0]);
        cmp_bit("chop_other", 1'h1, |drive.phase_on[3:2]);
        repeat (OFF_CYCLES - 1) @(negedge sys_clk);
        cmp_bit("chop_off_end", 1'h0, |drive.phase_on[1:0]);
        @(negedge sys_clk);
        cmp_bit("chop_on", 1'h1, |drive.phase_on[1:0]);
        u_ctrl.sync_pin(1'h1);
        repeat (2) @(negedge sys_clk);
        trip_pulse(2'h1);
        repeat (OFF_CYCLES + 4) @(negedge sys_clk);
        cmp_bit("sync_wait", 1'h0, |drive.phase_on[1:0]);
        trip_pulse(2'h2);
        repeat (OFF_CYCLES - 1) @(negedge sys_clk);
        cmp_bit("sync_end", 1'h0, |drive.phase_on);
        @(negedge sys_clk);
        cmp_bit("sync_a", 1'h1, |drive.phase_on[1:0]);
        cmp_bit("sync_b", 1'h1, |drive.phase_on[3:2]);
        u_ctrl.sync_pin(1'h0);
    endtask : t_chop
    // ------------------------------------------------
    // Run control
    // ------------------------------------------------
    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        rst_n      = 1'h0;
        clk_en     = 1'h1;
        vref       = 8'hC0;
        coil_trip  = 2'h0;
        exp_pos    = HOME_STEP;
        n_mismatch = 0;
        checks     = 0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'h1;
        @(negedge sys_clk);
        cmp_pos("power_on"); // home state
        cmp_bit("sync_reset", 1'h0, sync_active); // cleared
        t_modes();
        t_hold();
        t_home();
        t_disable();
        t_sync();
        t_reset();
        t_chop();
        end_sim();
    end
endmodule : tb
